// ---- imager_scan_readout_timing.sv ----
// scan, readout and injection timing for the charge injection imager camera
//
// Summary of operation
// - scan_mode_switch picks normal or synthetic-interlace scan timing.
// - normal scan gives 525 lines per frame, 488 visible, 2:1 interlace.
// - normal scan takes every other line of a field from redundant data.
// - synthetic-interlace drops the extra half line, fields not interlaced.
// - synthetic-interlace blanks redundant lines, leaving 244 ordered visible lines.
// - sequential mode keeps line frequency within about 0.1 percent.
// - readout mode switch picks pre-inject or nondestructive, independent of scan.
// - pre-inject readout injects every frame, giving fixed one-frame integration.
// - nondestructive readout keeps normal line and field readout during integration.
// - nondestructive integration lasts until the first frame end after three seconds.
// - saturation detector input triggers injection and a new integration period.
// - with detector bypassed the manual inject input, not the detector, triggers injections.
// - nominal timing is 60 fields, 30 frames and 525 lines per second/frame.
// - sequential scan uses whole-line fields, 524 lines per frame.
`timescale 1ns/1ps
`include "imager_timing_params.svh"

module imager_scan_readout_timing
	import imager_timing_pkg::*;
#(
	parameter logic [27:0] INTEG_MAX_CYC = 28'(`INTEG_MAX_CYC)
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// rear panel pins
	input wire logic i_scan_mode_switch,
	input wire logic i_nondestructive_readout_mode,
	input wire logic i_threshold_bypass,
	input wire logic i_sat_detect,
	input wire logic i_manual_inject,
	// sensor readout stream
	input wire logic [7:0] i_pix_data,
	input wire logic [7:0] i_pix_red_data,
	input wire logic i_pix_valid,
	output logic o_pix_ready,
	// video stream to the output stage
	output logic [7:0] o_vid_data,
	output logic o_vid_valid,
	input wire logic i_vid_ready,
	// timing to sensor and monitor
	output logic o_hsync,
	output logic o_vsync,
	output logic o_field,
	output logic o_line_visible,
	output logic o_use_redundant,
	output logic [7:0] o_sensor_row,
	output logic o_inject,
	// active modes
	output logic o_scan_sequential,
	output logic o_readout_nondestructive
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int NPIN = 5;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] meta_q;
	logic [NPIN-1:0] sync_q;

	assign pin_raw = {i_manual_inject, i_sat_detect, i_threshold_bypass,
		i_nondestructive_readout_mode, i_scan_mode_switch};

	genvar g;
	generate
		for (g = 0; g < NPIN; g++) begin : g_sync
			always_ff @(posedge i_clk) begin
				meta_q[g] <= i_sys_rst ? 1'b0 : pin_raw[g];
				sync_q[g] <= i_sys_rst ? 1'b0 : meta_q[g];
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// half-line and frame counters
	// ------------------------------------------------------------
	scan_mode_t scan_q;
	readout_mode_t read_q;
	logic [10:0] cyc_q;
	half_line_t hl_q;
	half_line_t hl_last;
	half_line_t field_start;
	logic half_end;
	logic frame_end;

	// seq fields are whole lines: the frame is 1048 half lines, field 1 starts on a line edge
	assign hl_last = (scan_q == SCAN_SEQUENTIAL) ? 11'(`HL_FRAME_SEQ - 1) :
		11'(`HL_FRAME_NORMAL - 1);
	assign field_start = (scan_q == SCAN_SEQUENTIAL) ? 11'(`LINES_SEQ) :
		11'(`LINES_NORMAL);
	assign half_end = (cyc_q == 11'(`HALF_LINE_CYC - 1));
	assign frame_end = half_end && (hl_q == hl_last);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cyc_q <= 11'h000;
			hl_q <= 11'h000;
		end else begin
			cyc_q <= half_end ? 11'h000 : cyc_q + 11'd1;
			// same line period in both modes keeps the line rate unchanged
			if (half_end)
				hl_q <= (hl_q == hl_last) ? 11'h000 : hl_q + 11'd1;
		end
	end

	// modes switch only as a new frame starts
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			scan_q <= SCAN_NORMAL;
			read_q <= READ_PREINJECT;
		end else if (frame_end) begin
			scan_q <= scan_mode_t'(sync_q[0]);
			read_q <= readout_mode_t'(sync_q[1]);
		end
	end

	// ------------------------------------------------------------
	// line decode
	// ------------------------------------------------------------
	function automatic logic in_range(input logic [10:0] v, input logic [10:0] lo,
		input logic [10:0] hi);
		in_range = (v >= lo) && (v < hi);
	endfunction

	logic field;
	half_line_t fhl;
	logic [9:0] fline;
	logic [9:0] vline;
	logic visible;
	logic redundant;
	logic hsync_d;
	logic vsync_d;

	assign field = (hl_q >= field_start);
	assign fhl = field ? hl_q - field_start : hl_q;
	assign fline = 10'((fhl + 11'd1) >> 1);
	assign vline = fline - 10'(`VBLANK_LINES);
	// 244 lines of each field are visible: 488 per interlaced frame
	assign visible = in_range({1'b0, fline}, 11'(`VBLANK_LINES),
		11'(`VBLANK_LINES + `SENSOR_ROWS));
	assign redundant = vline[0];
	assign hsync_d = !hl_q[0] && in_range(cyc_q, 11'h000, 11'(`HSYNC_CYC));
	assign vsync_d = in_range(fhl, 11'h000, 11'(`VSYNC_HALF_LINES));

	// ------------------------------------------------------------
	// injection control
	// ------------------------------------------------------------
	logic sat_prev_q;
	logic man_prev_q;
	logic pend_q;
	logic [27:0] integ_q;
	logic trig;
	logic integ_full;
	logic fire;

	// an edge of the selected source asks for injection
	assign trig = sync_q[2] ? (sync_q[4] && !man_prev_q) :
		(sync_q[3] && !sat_prev_q);
	assign integ_full = (integ_q >= INTEG_MAX_CYC - 28'd1);
	// injection waits for the frame edge so no readout is cut in half
	assign fire = frame_end && ((read_q == READ_PREINJECT) || pend_q ||
		trig || integ_full);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			sat_prev_q <= 1'b0;
			man_prev_q <= 1'b0;
			pend_q <= 1'b0;
			integ_q <= 28'h000_0000;
		end else begin
			sat_prev_q <= sync_q[3];
			man_prev_q <= sync_q[4];
			// a request seen in the firing cycle itself is served by that firing
			pend_q <= fire ? 1'b0 : (pend_q || trig || integ_full);
			integ_q <= fire ? 28'h000_0000 : (integ_full ? integ_q : integ_q + 28'd1);
		end
	end

	// ------------------------------------------------------------
	// registered timing outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_hsync <= 1'b0;
			o_vsync <= 1'b0;
			o_field <= 1'b0;
			o_line_visible <= 1'b0;
			o_use_redundant <= 1'b0;
			o_sensor_row <= 8'h00;
			o_inject <= 1'b0;
			o_scan_sequential <= 1'b0;
			o_readout_nondestructive <= 1'b0;
		end else begin
			o_hsync <= hsync_d;
			o_vsync <= vsync_d;
			o_field <= field;
			// redundant lines are blanked in sequential mode
			o_line_visible <= visible && !(scan_q == SCAN_SEQUENTIAL && redundant);
			o_use_redundant <= visible && redundant;
			o_sensor_row <= visible ? {vline[7:1], field} : 8'h00;
			o_inject <= fire;
			o_scan_sequential <= (scan_q == SCAN_SEQUENTIAL);
			o_readout_nondestructive <= (read_q == READ_NONDESTRUCTIVE);
		end
	end

	// ------------------------------------------------------------
	// two-entry video buffer
	// ------------------------------------------------------------
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	pixel_t tail_q;
	pixel_t pix_sel;
	logic push;
	logic pop;

	// blanked lines still drain the sensor but show black
	assign pix_sel = !o_line_visible ? 8'h00 :
		(o_use_redundant ? i_pix_red_data : i_pix_data);
	assign push = i_pix_valid && o_pix_ready;
	assign pop = o_vid_valid && i_vid_ready;
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_q <= 2'h0;
			tail_q <= 8'h00;
			o_vid_data <= 8'h00;
			o_vid_valid <= 1'b0;
			o_pix_ready <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			o_vid_valid <= (cnt_d != 2'h0);
			o_pix_ready <= (cnt_d != 2'h2);
			if (pop && cnt_q == 2'h2)
				o_vid_data <= tail_q;
			else if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
				o_vid_data <= pix_sel;
			if (push && ((cnt_q == 2'h1 && !pop) || cnt_q == 2'h2))
				tail_q <= pix_sel;
		end
	end

endmodule // imager_scan_readout_timing

// ---- imager_timing_params.svh ----
// timing constants and counts for the imager scan and readout timing block
`ifndef IMAGER_TIMING_PARAMS_SVH
`define IMAGER_TIMING_PARAMS_SVH

// ------------------------------------------------------------
// clock
// ------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define CLK_HZ 50000000

// ------------------------------------------------------------
// line and field geometry
// ------------------------------------------------------------
`define LINE_TIME_NS 63500
`define HALF_LINE_CYC ((`LINE_TIME_NS / 2) / `CLK_PERIOD_NS)
`define HSYNC_TIME_NS 4700
`define HSYNC_CYC ((`HSYNC_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LINES_NORMAL 525
`define VISIBLE_NORMAL 488
`define LINES_SEQ 524
`define SENSOR_ROWS 244
`define VBLANK_LINES 18
`define VSYNC_HALF_LINES 6
`define HL_FRAME_NORMAL (2 * `LINES_NORMAL)
`define HL_FRAME_SEQ (2 * `LINES_SEQ)

// ------------------------------------------------------------
// integration
// ------------------------------------------------------------
`define PREINJECT_TIME_MS 33
`define INTEG_MAX_S 3
`define INTEG_MAX_CYC (`INTEG_MAX_S * `CLK_HZ)

`endif

// ---- imager_timing_pkg.sv ----
// types shared by the imager scan and readout timing block
package imager_timing_pkg;
	typedef enum logic {SCAN_NORMAL, SCAN_SEQUENTIAL} scan_mode_t;
	typedef enum logic {READ_PREINJECT, READ_NONDESTRUCTIVE} readout_mode_t;
	typedef logic [10:0] half_line_t;
	typedef logic [7:0] pixel_t;
endpackage

// ---- imager_timing_chk.sv ----
// concurrent checks on the ports of the imager scan and readout timing block
`timescale 1ns/1ps
module imager_timing_chk
	import imager_timing_pkg::*;
#(
	parameter logic [27:0] INTEG_MAX_CYC = 28'h000_0bb8
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_pix_valid,
	input wire logic i_vid_ready,
	input wire logic o_pix_ready,
	input wire logic o_vid_valid,
	input wire logic [7:0] o_vid_data,
	input wire logic o_hsync,
	input wire logic o_vsync,
	input wire logic o_field,
	input wire logic o_line_visible,
	input wire logic o_use_redundant,
	input wire logic [7:0] o_sensor_row,
	input wire logic o_inject
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	logic [11:0] hs_len_q;
	logic [11:0] hs_per_q;
	logic [1:0] occ_q;
	wire push = i_pix_valid && o_pix_ready;
	wire pop = o_vid_valid && i_vid_ready;
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			hs_len_q <= '0;
			hs_per_q <= '0;
			occ_q <= '0;
		end else begin
			hs_len_q <= o_hsync ? hs_len_q + 12'd1 : '0;
			hs_per_q <= $rose(o_hsync) ? 12'd1 : hs_per_q + 12'd1;
			occ_q <= occ_q + 2'(push) - 2'(pop);
		end
	end
	// ----
	// assertions
	// ----
	property p_hs_width; $fell(o_hsync) |-> hs_len_q == 12'd235; endproperty
	a_hs_width: assert property (p_hs_width) else $error("hsync width");
	// first pulse after reset has no full period behind it
	property p_hs_per; $rose(o_hsync) && hs_per_q > 12'd300 |-> hs_per_q == 12'd3174; endproperty
	a_hs_per: assert property (p_hs_per) else $error("line period");
	property p_vs_blank; o_vsync |-> !o_line_visible; endproperty
	a_vs_blank: assert property (p_vs_blank) else $error("visible in vsync");
	// blanked redundant lines in sequential scan still address the sensor row
	property p_row_blank;
		!o_line_visible && !o_use_redundant |-> o_sensor_row == 8'h00;
	endproperty
	a_row_blank: assert property (p_row_blank) else $error("row when blank");
	property p_row_field; o_line_visible |-> o_sensor_row[0] == o_field; endproperty
	a_row_field: assert property (p_row_field) else $error("row field bit");
	property p_inject; o_inject |=> !o_inject; endproperty
	a_inject: assert property (p_inject) else $error("inject width");
	property p_hold; o_vid_valid && !i_vid_ready |=> o_vid_valid && $stable(o_vid_data); endproperty
	a_hold: assert property (p_hold) else $error("video not held");
	property p_full; occ_q == 2'd2 |-> !o_pix_ready && o_vid_valid; endproperty
	a_full: assert property (p_full) else $error("full not refused");
	c_full: cover property (occ_q == 2'd2);
	c_pop: cover property (pop);
	c_vis: cover property ($rose(o_line_visible));
endmodule // imager_timing_chk
bind imager_scan_readout_timing imager_timing_chk #(.INTEG_MAX_CYC(INTEG_MAX_CYC)) chk_u (.*);

// ---- imager_far_side_model.sv ----
// sensor pixel source and monitor sink facing the timing block
`timescale 1ns/1ps
module imager_far_side_model (
	// clock, reset and scenario control
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_en,
	input wire logic i_stall,
	// pixel side
	input wire logic i_pix_ready,
	output logic o_pix_valid,
	output logic [7:0] o_pix_data,
	output logic [7:0] o_pix_red_data,
	output logic [7:0] o_taken,
	// video side
	output logic o_vid_ready
);
	// an offered word holds until taken; released lines show the inverse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_taken <= '0;
			o_pix_valid <= 1'b0;
		end else begin
			o_taken <= o_taken + 8'(o_pix_valid && i_pix_ready);
			o_pix_valid <= i_en || (o_pix_valid && !i_pix_ready);
		end
	end
	assign o_pix_data = o_pix_valid ? o_taken : ~o_taken;
	assign o_pix_red_data = o_pix_valid ? o_taken ^ 8'h5a : ~(o_taken ^ 8'h5a);
	assign o_vid_ready = !i_stall;
endmodule // imager_far_side_model

// ---- testbench.sv ----
// self-checking bench for the imager scan and readout timing block
`timescale 1ns/1ps
module testbench;
	import imager_timing_pkg::*;
	logic i_clk, i_sys_rst, i_scan_mode_switch, i_nondestructive_readout_mode;
	logic i_threshold_bypass, i_sat_detect, i_manual_inject, i_pix_valid, o_pix_ready;
	logic o_vid_valid, i_vid_ready, o_hsync, o_vsync, o_field, o_line_visible;
	logic o_use_redundant, o_inject, o_scan_sequential, o_readout_nondestructive;
	logic [7:0] i_pix_data, i_pix_red_data, o_vid_data, o_sensor_row, taken;
	logic en, stall;
	int bad_count, n_tests, t, n, h;
	imager_scan_readout_timing #(.INTEG_MAX_CYC(28'h000_0bb8)) dut_u (.*);
	imager_far_side_model far_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_en(en),
		.i_stall(stall), .i_pix_ready(o_pix_ready), .o_pix_valid(i_pix_valid),
		.o_pix_data(i_pix_data), .o_pix_red_data(i_pix_red_data), .o_taken(taken),
		.o_vid_ready(i_vid_ready));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	always @(posedge i_clk) t <= i_sys_rst ? 0 : t + 1;
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge i_clk);
	endtask
	// bounded, so a stuck output cannot hang the run
	task automatic run_len(input bit v, input logic lvl, output int k);
		k = 0;
		while ((v ? o_vsync : o_hsync) === lvl && k < 20000) begin
			cyc(1);
			k++;
		end
	endtask
	// kind: 0 blanked, 1 primary, 2 redundant
	task automatic fifo(input string what, input int kind);
		int base, k;
		logic [7:0] e;
		base = taken;
		stall <= 1'b1;
		en <= 1'b1;
		cyc(8);
		chk({what, " held"}, 16'd2, 16'(taken - 8'(base)));
		chk({what, " refused"}, 16'd0, 16'(o_pix_ready));
		en <= 1'b0;
		stall <= 1'b0;
		k = 0;
		repeat (20) begin
			cyc(1);
			if (o_vid_valid === 1'b1 && i_vid_ready === 1'b1) begin
				e = 8'(base + k);
				chk(what, 16'(kind == 0 ? 8'h00 : kind == 2 ? e ^ 8'h5a : e), 16'(o_vid_data));
				k++;
			end
		end
		chk({what, " count"}, 16'd3, 16'(k));
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#2_000_000;
		bad_count++;
		conclude();
	end
	initial begin
		{i_sys_rst, en, stall} <= 3'b100;
		{i_scan_mode_switch, i_nondestructive_readout_mode, i_threshold_bypass} <= 3'b000;
		{i_sat_detect, i_manual_inject} <= 2'b00;
		cyc(20);
		chk("reset ready", 16'd0, 16'(o_pix_ready));
		chk("reset hsync", 16'd0, 16'(o_hsync));
		i_sys_rst <= 1'b0;
		// new modes must wait for the frame boundary
		i_scan_mode_switch <= 1'b1;
		i_nondestructive_readout_mode <= 1'b1;
		i_threshold_bypass <= 1'b1;
		$display("test reset done");
		run_len(1, 1'b0, n);
		run_len(1, 1'b1, h);
		chk("vsync width", 16'd9522, 16'(h));
		run_len(0, 1'b1, n);
		run_len(0, 1'b0, n);
		run_len(0, 1'b1, h);
		run_len(0, 1'b0, n);
		chk("hsync width", 16'd235, 16'(h));
		chk("line period", 16'd3174, 16'(h + n));
		$display("test sync done");
		chk("blank visible", 16'd0, 16'(o_line_visible));
		fifo("blank data", 0);
		$display("test blank done");
		i_manual_inject <= 1'b1;
		i_sat_detect <= 1'b1;
		h = 0;
		repeat (300) begin
			cyc(1);
			h += (o_inject === 1'b1);
		end
		chk("inject deferred", 16'd0, h);
		{i_sat_detect, i_manual_inject} <= 2'b00;
		$display("test inject done");
		for (int i = 0; i < 3; i++) begin
			while (t < 56500 + 3174 * i) cyc(1);
			chk("scan mode", 16'd0, 16'(o_scan_sequential));
			chk("readout mode", 16'd0, 16'(o_readout_nondestructive));
			chk("visible", 16'd1, 16'(o_line_visible));
			chk("field", 16'd0, 16'(o_field));
			chk("redundant", 16'(i == 1), 16'(o_use_redundant));
			chk("row", i == 2 ? 16'd2 : 16'd0, 16'(o_sensor_row));
			fifo("line data", i == 1 ? 2 : 1);
		end
		$display("test lines done");
		conclude();
	end
endmodule // testbench
